/* pkg/twug_pkg.sv */
package twug_pkg;

  localparam int SFR_AW = 8;
  localparam int SFR_DW = 8;

  // Register offsets on the internal special function register bus
  localparam logic [7:0] TIMED_ACCESS_KEY_ADDR = 8'h00_C7;
  localparam logic [7:0] WATCHDOG_CONTROL_ADDR = 8'h00_D8;
  localparam logic [7:0] BROWNOUT_CONTROL_ADDR = 8'h00_A3;

  // Key values
  localparam logic [7:0] KEY_FIRST = 8'h00_AA;
  localparam logic [7:0] KEY_SECOND = 8'h00_55;

  // Reset values
  localparam logic [7:0] TIMED_ACCESS_KEY_RST = 8'h00_00;
  localparam logic [7:0] WATCHDOG_CONTROL_RST = 8'h00_00;
  localparam logic [7:0] BROWNOUT_CONTROL_RST = 8'h00_00;

  // Protected bit masks
  localparam logic [7:0] WATCHDOG_CONTROL_PMASK = 8'h00_FF;
  localparam logic [7:0] BROWNOUT_CONTROL_PMASK = 8'h00_FF;

  // Timing, in clock cycles, and counter width in bits
  localparam int ARM_CYCLES = 3;
  localparam int WINDOW_CYCLES = 4;
  localparam int CNT_W = 3;

  typedef enum logic [1:0] {
    TWUG_IDLE = 2'b00,
    TWUG_ARMED = 2'b01,
    TWUG_OPEN = 2'b10
  } twug_state_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } twug_req_s;

  typedef struct packed {
    logic [7:0] watchdog_control;
    logic [7:0] brownout_control;
  } twug_ctrl_s;

endpackage : twug_pkg

/* verilog/twug_prot_reg.sv */
`timescale 1ns/1ps
`default_nettype none

module twug_prot_reg #(
  parameter logic [7:0] RST = 8'h00_00,
  parameter logic [7:0] PMASK = 8'h00_FF
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic wr_sel,
  input wire logic window_open,
  input wire logic [7:0] wdata,
  output logic [7:0] q
);

  logic [7:0] q_r;
  logic [7:0] q_nxt;

  // Protected bits change only while the window is open; others always
  always_comb begin
    q_nxt = q_r;
    if (wr_sel) begin
      if (window_open) begin
        q_nxt = wdata;
      end else begin
        q_nxt = (q_r & PMASK) | (wdata & ~PMASK);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      q_r <= RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign q = q_r;

endmodule : twug_prot_reg

`default_nettype wire

/* verilog/twug_guard.sv */
`timescale 1ns/1ps
`default_nettype none

module twug_guard (
  input wire logic clock,
  input wire logic rst,
  input wire twug_pkg::twug_req_s req,
  output logic [7:0] rdata,
  output logic rvalid,
  output logic window_open,
  output twug_pkg::twug_ctrl_s ctrl
);

  twug_pkg::twug_state_e state_r;
  twug_pkg::twug_state_e state_nxt;
  logic [twug_pkg::CNT_W-1:0] cnt_r;
  logic [twug_pkg::CNT_W-1:0] cnt_nxt;
  logic [7:0] key_r;
  logic [7:0] key_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  logic key_wr;
  logic open_now;
  logic wd_sel;
  logic bo_sel;
  logic [7:0] wd_q;
  logic [7:0] bo_q;

  assign key_wr = req.wr && (req.addr == twug_pkg::TIMED_ACCESS_KEY_ADDR);
  assign wd_sel = req.wr && (req.addr == twug_pkg::WATCHDOG_CONTROL_ADDR);
  assign bo_sel = req.wr && (req.addr == twug_pkg::BROWNOUT_CONTROL_ADDR);
  // A write is accepted only in a cycle where the window is active
  assign open_now = (state_r == twug_pkg::TWUG_OPEN);

  // Unlock sequencer
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    key_nxt = key_r;
    if (key_wr) begin
      key_nxt = req.wdata;
    end
    unique case (state_r)
      twug_pkg::TWUG_IDLE: begin
        if (key_wr && req.wdata == twug_pkg::KEY_FIRST) begin
          state_nxt = twug_pkg::TWUG_ARMED;
          cnt_nxt = twug_pkg::CNT_W'(twug_pkg::ARM_CYCLES);
        end
      end
      twug_pkg::TWUG_ARMED: begin
        if (key_wr && req.wdata == twug_pkg::KEY_SECOND) begin
          state_nxt = twug_pkg::TWUG_OPEN;
          cnt_nxt = twug_pkg::CNT_W'(twug_pkg::WINDOW_CYCLES);
        end else if (key_wr && req.wdata == twug_pkg::KEY_FIRST) begin
          cnt_nxt = twug_pkg::CNT_W'(twug_pkg::ARM_CYCLES);
        end else if (key_wr) begin
          state_nxt = twug_pkg::TWUG_IDLE;
          cnt_nxt = '0;
        end else if (cnt_r <= twug_pkg::CNT_W'(1)) begin
          state_nxt = twug_pkg::TWUG_IDLE;
          cnt_nxt = '0;
        end else begin
          cnt_nxt = cnt_r - twug_pkg::CNT_W'(1);
        end
      end
      twug_pkg::TWUG_OPEN: begin
        if (cnt_r <= twug_pkg::CNT_W'(1)) begin
          state_nxt = twug_pkg::TWUG_IDLE;
          cnt_nxt = '0;
        end else begin
          cnt_nxt = cnt_r - twug_pkg::CNT_W'(1);
        end
        if (key_wr && req.wdata == twug_pkg::KEY_FIRST) begin
          state_nxt = twug_pkg::TWUG_ARMED;
          cnt_nxt = twug_pkg::CNT_W'(twug_pkg::ARM_CYCLES);
        end
      end
      default: begin
        state_nxt = twug_pkg::TWUG_IDLE;
        cnt_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= twug_pkg::TWUG_IDLE;
      cnt_r <= '0;
      key_r <= twug_pkg::TIMED_ACCESS_KEY_RST;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      key_r <= key_nxt;
    end
  end

  twug_prot_reg #(
    .RST(twug_pkg::WATCHDOG_CONTROL_RST),
    .PMASK(twug_pkg::WATCHDOG_CONTROL_PMASK)
  ) u_watchdog_control (
    .clock(clock),
    .rst(rst),
    .wr_sel(wd_sel),
    .window_open(open_now),
    .wdata(req.wdata),
    .q(wd_q)
  );

  twug_prot_reg #(
    .RST(twug_pkg::BROWNOUT_CONTROL_RST),
    .PMASK(twug_pkg::BROWNOUT_CONTROL_PMASK)
  ) u_brownout_control (
    .clock(clock),
    .rst(rst),
    .wr_sel(bo_sel),
    .window_open(open_now),
    .wdata(req.wdata),
    .q(bo_q)
  );

  // Read path: protected registers readable any time, key reads as zero
  always_comb begin
    rdata_nxt = 8'h00_00;
    rvalid_nxt = req.rd;
    if (req.rd) begin
      unique case (req.addr)
        twug_pkg::WATCHDOG_CONTROL_ADDR: rdata_nxt = wd_q;
        twug_pkg::BROWNOUT_CONTROL_ADDR: rdata_nxt = bo_q;
        default: rdata_nxt = 8'h00_00;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_r <= 8'h00_00;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign rdata = rdata_r;
  assign rvalid = rvalid_r;
  assign window_open = open_now;
  assign ctrl.watchdog_control = wd_q;
  assign ctrl.brownout_control = bo_q;

endmodule : twug_guard

`default_nettype wire

/* verif/twug_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module twug_chk (
  input wire logic clock,
  input wire logic rst,
  input wire twug_pkg::twug_req_s req,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire logic window_open,
  input wire twug_pkg::twug_ctrl_s ctrl
);
  logic kw, ka, kb, wa;
  assign kw = req.wr && req.addr == twug_pkg::TIMED_ACCESS_KEY_ADDR;
  assign ka = kw && req.wdata == twug_pkg::KEY_FIRST;
  assign kb = kw && req.wdata == twug_pkg::KEY_SECOND;
  assign wa = req.addr == twug_pkg::WATCHDOG_CONTROL_ADDR;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence unlock_s;
    ka ##1 kb;
  endsequence
  sequence late_s;
    ka ##1 !kw [*3] ##1 kb;
  endsequence
  a_key_opens: assert property (unlock_s |=> window_open)
    else $error("window shut");
  a_late_shut: assert property (late_s |=> !window_open)
    else $error("late open");
  a_cancel_key: assert property (ka ##1 (kw && !kb && !ka) |=> !window_open [*2])
    else $error("no cancel");
  a_closed_hold: assert property (!window_open |=> $stable(ctrl))
    else $error("closed write");
  a_open_write: assert property (window_open && req.wr && wa |=>
    ctrl.watchdog_control == $past(req.wdata))
    else $error("write lost");
  a_window_len: assert property ($fell(window_open) && !$past(ka) |-> $past(window_open, 4))
    else $error("short window");
  a_window_ends: assert property ($rose(window_open) ##0 !ka [*4] |=> !window_open)
    else $error("long window");
  a_read_back: assert property (req.rd && wa |=>
    rvalid && rdata == $past(ctrl.watchdog_control))
    else $error("bad read");
  a_key_hidden: assert property (req.rd && req.addr == 8'h00_C7 |=> rdata == 8'h00_00)
    else $error("key readable");
endmodule : twug_chk
bind twug_guard twug_chk chk (.clock(clock), .rst(rst), .req(req), .rdata(rdata),
  .rvalid(rvalid), .window_open(window_open), .ctrl(ctrl));
`default_nettype wire

/* verif/twug_cpu.sv */
`timescale 1ns/1ps
`default_nettype none
module twug_cpu (
  input wire logic clock,
  input wire logic [7:0] rdata,
  output twug_pkg::twug_req_s req
);
  initial req = '0;
  // One access per cycle, back to back with no forced gap
  task automatic acc(input logic [1:0] op, input logic [7:0] a, input logic [7:0] v);
    @(negedge clock);
    req = {op, a, v};
  endtask : acc
  task automatic idle;
    acc(2'b00, ~req.addr, ~req.wdata);
  endtask : idle
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    acc(2'b01, a, ~req.wdata);
    idle();
    v = rdata;
  endtask : rd
endmodule : twug_cpu
`default_nettype wire

/* verif/tb_timed_write_unlock_guard.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_timed_write_unlock_guard;
  localparam logic [7:0] WD = twug_pkg::WATCHDOG_CONTROL_ADDR;
  logic clock = 1'b0;
  logic rst = 1'b1;
  twug_pkg::twug_req_s req;
  logic [7:0] rdata;
  logic rvalid;
  logic window_open;
  twug_pkg::twug_ctrl_s ctrl;
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  twug_guard DUT (.clock(clock), .rst(rst), .req(req), .rdata(rdata), .rvalid(rvalid),
    .window_open(window_open), .ctrl(ctrl));
  twug_cpu cpu (.clock(clock), .rdata(rdata), .req(req));
  initial forever #25 clock = ~clock;
  task automatic unlock(input int g);
    cpu.acc(2'b10, 8'h00_C7, twug_pkg::KEY_FIRST);
    repeat (g) cpu.idle();
    cpu.acc(2'b10, 8'h00_C7, twug_pkg::KEY_SECOND);
  endtask : unlock
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    repeat (6) cpu.idle();
    cpu.rd(a, v);
    num_checks++;
    if (v !== e || rvalid !== 1'b1) begin
      err_count++;
      $display("unexpected at %0t: read %h want %h", $time, v, e);
    end
    if (a == WD && ctrl.watchdog_control !== e) begin
      err_count++;
      $display("unexpected at %0t: control %h want %h", $time, ctrl.watchdog_control, e);
    end
    if (window_open !== 1'b0) begin
      err_count++;
      $display("unexpected at %0t: window still open", $time);
    end
  endtask : rchk
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_count++;
      end_of_test();
    end
  end
  initial begin
    repeat (6) @(negedge clock);
    rst = 1'b0;
    rchk(8'h00_C7, twug_pkg::TIMED_ACCESS_KEY_RST);
    cpu.acc(2'b10, WD, 8'h00_5A);
    rchk(WD, twug_pkg::WATCHDOG_CONTROL_RST);
    $display("test closed write done");
    for (int g = 0; g < 4; g++) begin
      unlock(g);
      cpu.acc(2'b10, WD, 8'(16 + g));
      rchk(WD, (g < 3) ? 8'(16 + g) : 8'h00_12);
    end
    $display("test key spacing done");
    unlock(0);
    repeat (3) cpu.idle();
    cpu.acc(2'b10, twug_pkg::BROWNOUT_CONTROL_ADDR, 8'h00_C3);
    cpu.acc(2'b10, twug_pkg::BROWNOUT_CONTROL_ADDR, 8'h00_11);
    rchk(twug_pkg::BROWNOUT_CONTROL_ADDR, 8'h00_C3);
    $display("test window length done");
    cpu.acc(2'b10, 8'h00_C7, twug_pkg::KEY_FIRST);
    cpu.acc(2'b10, 8'h00_C7, 8'h00_33);
    cpu.acc(2'b10, 8'h00_C7, twug_pkg::KEY_SECOND);
    cpu.acc(2'b10, WD, 8'h00_EE);
    rchk(WD, 8'h00_12);
    $display("test cancel done");
    end_of_test();
  end
endmodule : tb_timed_write_unlock_guard
`default_nettype wire
